// ### pkg/vlc_pkg.sv
// shared constants and types for the link command and status block
package vlc_pkg;
    // register byte addresses
    localparam logic [3:0] VLC_ADDR_CMD  = 4'h0;  // command byte plus data byte
    localparam logic [3:0] VLC_ADDR_CFG  = 4'h4;  // active configuration
    localparam logic [3:0] VLC_ADDR_STAT = 4'h8;  // status byte
    // command byte field positions
    localparam int VLC_GENERAL_COMMAND_LSB = 5;
    localparam int VLC_BYTE_TYPE_DESTINATION_LSB = 2;
    localparam int VLC_RFC_LSB  = 0;
    localparam int VLC_DATA_LSB = 8;
    // configuration byte field positions
    localparam int VLC_TC_LSB   = 0;
    localparam int VLC_TM_BIT   = 2;
    localparam int VLC_INTERRUPT_MASK_BIT = 3;
    localparam int VLC_INTERRUPT_SOURCE_MODE_BIT = 4;
    localparam int VLC_CLOCK_DIVISOR_LSB = 5;
    localparam int VLC_HS_BIT   = 7;
    localparam logic [7:0] VLC_CFG_RESET = 8'h00;
    // general command codes
    localparam logic [2:0] GC_NOP = 3'h0, GC_STBY = 3'h1, GC_BRK = 3'h2, GC_IFRC = 3'h3;
    localparam logic [2:0] GC_NORTY = 3'h4, GC_IFRN = 3'h5, GC_ABORT = 3'h7;
    // byte type codes
    localparam logic [2:0] BT_DROP = 3'h0, BT_MID = 3'h1, BT_LAST = 3'h3, BT_CFG = 3'h4;
    localparam logic [2:0] BT_FIRST = 3'h5, BT_CFGI = 3'h6, BT_ONLY = 3'h7;
    // receive buffer command codes
    localparam logic [1:0] RC_FLBYTE = 2'h2, RC_FLFRAME = 2'h3;
    // receive buffer state codes
    localparam logic [2:0] RS_EMPTY = 3'h0, RS_MANY = 3'h1, RS_CODE = 3'h2, RS_DATA13 = 3'h3;
    localparam logic [2:0] RS_ONE = 3'h4, RS_CODE_MORE = 3'h5, RS_CODE_FRM = 3'h6;
    localparam logic [2:0] RS_CODE_ONLY = 3'h7;
    localparam logic [3:0] VLC_RX_POS13 = 4'hd;
    // transmit buffer state codes
    localparam logic [1:0] TS_EMPTY = 2'h0, TS_DATA = 2'h1, TS_FULL = 2'h3;
    // status field positions
    localparam int VLC_ST_RX_LSB = 0;
    localparam int VLC_ST_IDLE   = 3;
    localparam int VLC_ST_FAULT  = 4;
    localparam int VLC_ST_HS     = 5;
    localparam int VLC_ST_TX_LSB = 6;
    localparam int VLC_ST_RES_LSB = 8;
    // timing
    localparam int VLC_CLK_KHZ       = 10000;
    localparam int VLC_FAULT_US      = 60;
    localparam int VLC_FAULT_CYC     = VLC_FAULT_US * VLC_CLK_KHZ / 1000;
    localparam int VLC_HS_FACTOR     = 4;
    localparam logic [1:0] AXI_OKAY  = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    // one entry of the transmit buffer
    typedef struct packed {
        logic [7:0] data;
        logic       first;
        logic       last;
    } vlc_txw_s;
    // one-cycle requests toward the link engine
    typedef struct packed {
        logic standby;
        logic brk;
        logic ifr;
        logic ifr_crc;
        logic stop_retry;
        logic abort;
        logic flush_byte;
        logic flush_frame;
    } vlc_req_s;
endpackage

// ### src/vlc_cmd_status.sv
// command decoder, configuration and status for the serial link controller
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
// What this block does
// - codes 011/101 request in-frame reply, crc differs
// - general command codes decode to link requests
// - byte type routes data into transmit buffer
// - 000 drops, 100 stages, 110 applies config
// - receive command flushes byte or frame
// - test mode bit and test field
// - mask bit suppresses every interrupt
// - mode bit adds one extra interrupt source
// - divisor field divides clock by 1..4 with high speed set, by 4..16 without
// - high speed bit runs timing four times faster
// - receive state reports data conditions
// - receive state reports completion code conditions
// - idle bit is one while bus idle
// - fault set when no activity within 60us while the transmitter drives
// - high speed status mirrors active rate
// - transmit buffer state empty, data, full
// - transmitter result field reported in status
module vlc_cmd_status
    import vlc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // axi4-lite write address and data
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // transmit byte stream
    output vlc_txw_s         tx_word,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    // requests to the link engine
    output vlc_req_s         req,
    // receive buffer state from the same clock
    input  wire logic [3:0]  rx_count,
    input  wire logic        rx_head_code,
    input  wire logic        rx_code_present,
    input  wire logic        rx_frame_behind,
    input  wire logic        frame_done,
    input  wire logic [1:0]  tx_result,
    // bus pin and transmitter drive
    input  wire logic        bus_active_pin,
    input  wire logic        tx_driving,
    // interrupt sources and output
    input  wire logic        irq_default,
    input  wire logic        irq_extra,
    output logic             irq,
    // configuration outputs
    output logic             link_tick,
    output logic             test_mode,
    output logic [1:0]       test_cfg
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic        aw_held;        // write address captured
    logic        w_held;         // write data captured
    logic [3:0]  wa;             // captured write address
    logic [31:0] wd;             // captured write data
    logic [7:0]  cfg;            // active configuration
    logic [7:0]  cfg_stage;      // staged configuration
    logic        stage_valid;    // staged value awaits frame end
    vlc_txw_s    buf_q [2];      // two-entry transmit buffer
    logic        rd_ptr;         // buffer read index
    logic        wr_ptr;         // buffer write index
    logic [1:0]  count;          // entries held
    logic [2:0]  b_pin;          // pin synchroniser
    logic        bus_act;        // agreed bus level
    logic [9:0]  flt_cnt;        // fault timer
    logic        fault;          // network fault flag
    logic [4:0]  div_cnt;        // link tick divider
    logic [7:0]  status;         // live status byte
    logic [2:0]  next_rxs;       // receive state encode
    logic [7:0]  cmd;            // command byte being executed
    logic [2:0]  bt;             // byte type of that command
    logic        is_tx;          // command loads transmit data
    logic        exec;           // command executes this cycle
    logic        push;           // buffer write
    logic        pop;            // buffer read
    logic [4:0]  div_end;        // divider terminal count

    assign cmd     = wd[7:0];
    assign bt      = cmd[VLC_BYTE_TYPE_DESTINATION_LSB +: 3];
    assign is_tx   = (bt == BT_MID) || (bt == BT_LAST) || (bt == BT_FIRST) || (bt == BT_ONLY);
    // a tx load waits for room, which holds off the write response
    assign exec    = ce && aw_held && w_held && !bvalid && (wa == VLC_ADDR_CMD)
                     && wstrb[0] && !(is_tx && (count == 2'h2));
    assign push    = exec && is_tx;
    assign pop     = ce && tx_valid && tx_ready;
    // tick period = divisor field plus one, times four unless high speed
    assign div_end = cfg[VLC_HS_BIT] ? 5'({3'h0, cfg[VLC_CLOCK_DIVISOR_LSB +: 2]})
                                     : 5'({cfg[VLC_CLOCK_DIVISOR_LSB +: 2], 2'h3});

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    // address and data are taken in either order, answered once both executed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            wa      <= 4'h0;
            wd      <= 32'h0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= AXI_OKAY;
        end else if (ce) begin
            awready <= !aw_held && !awready && !bvalid;
            wready  <= !w_held && !wready && !bvalid;
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                wa      <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wd     <= wdata;
                wready <= 1'b0;
            end
            if (aw_held && w_held && !bvalid) begin
                // status is read-only, unmapped answers slave error
                if (wa == VLC_ADDR_CMD) begin
                    if (exec || !wstrb[0]) begin
                        bvalid <= 1'b1;
                        bresp  <= AXI_OKAY;
                    end
                end else begin
                    bvalid <= 1'b1;
                    bresp  <= (wa == VLC_ADDR_CFG) ? AXI_OKAY : AXI_SLVERR;
                end
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    // reads have no side effect on any state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= AXI_OKAY;
        end else if (ce) begin
            arready <= !rvalid && !arready;
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rresp   <= AXI_OKAY;
                case (araddr)
                    VLC_ADDR_CFG:  rdata <= {24'h0, cfg};
                    VLC_ADDR_STAT: rdata <= {22'h0, tx_result, status};
                    VLC_ADDR_CMD:  rdata <= 32'h0;    // write-only
                    default: begin
                        rdata <= 32'h0;
                        rresp <= AXI_SLVERR;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // general and receive commands
    // ------------------------------------------------------------
    // one-cycle requests; reserved codes fall to default with none raised
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req <= '0;
        end else if (ce) begin
            req <= '0;
            if (exec) begin
                case (cmd[VLC_GENERAL_COMMAND_LSB +: 3])
                    GC_STBY:  req.standby    <= 1'b1;
                    GC_BRK:   req.brk        <= 1'b1;
                    GC_NORTY: req.stop_retry <= 1'b1;
                    GC_ABORT: req.abort      <= 1'b1;
                    GC_IFRC: begin
                        req.ifr     <= 1'b1;
                        req.ifr_crc <= 1'b1;
                    end
                    GC_IFRN:  req.ifr        <= 1'b1;
                    default:  req <= '0;
                endcase
                case (cmd[VLC_RFC_LSB +: 2])
                    RC_FLBYTE:  req.flush_byte  <= 1'b1;
                    RC_FLFRAME: req.flush_frame <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    // staged value waits for frame end so a running frame keeps its timing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg         <= VLC_CFG_RESET;
            cfg_stage   <= VLC_CFG_RESET;
            stage_valid <= 1'b0;
        end else if (ce) begin
            if (frame_done && stage_valid) begin
                cfg         <= cfg_stage;
                stage_valid <= 1'b0;
            end
            if (exec && bt == BT_CFG) begin
                cfg_stage   <= wd[VLC_DATA_LSB +: 8];
                stage_valid <= 1'b1;
            end
            if (exec && bt == BT_CFGI) begin
                cfg <= wd[VLC_DATA_LSB +: 8];
            end
            if (aw_held && w_held && !bvalid && wa == VLC_ADDR_CFG && wstrb[0]) begin
                cfg <= wdata_cfg(wd);
            end
        end
    end

    // direct write of the configuration word
    function automatic logic [7:0] wdata_cfg(input logic [31:0] v);
        return v[7:0];
    endfunction

    // test mode only takes effect with the select bit set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_mode <= 1'b0;
            test_cfg  <= 2'h0;
        end else if (ce) begin
            test_mode <= cfg[VLC_TM_BIT];
            test_cfg  <= cfg[VLC_TM_BIT] ? cfg[VLC_TC_LSB +: 2] : 2'h0;
        end
    end

    // ------------------------------------------------------------
    // transmit buffer, two entries
    // ------------------------------------------------------------
    // entry written per index; first/last flags follow the byte type
    for (genvar i = 0; i < 2; i++) begin : g_ent
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                buf_q[i] <= '0;
            end else if (push && wr_ptr == 1'(i)) begin
                buf_q[i].data  <= wd[VLC_DATA_LSB +: 8];
                buf_q[i].first <= bt[2];
                buf_q[i].last  <= bt[1];
            end
        end
    end

    // pointers and count; abort empties the buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count  <= 2'h0;
        end else if (ce) begin
            if (req.abort) begin
                rd_ptr <= 1'b0;
                wr_ptr <= 1'b0;
                count  <= 2'h0;
            end else begin
                if (push) wr_ptr <= ~wr_ptr;
                if (pop) rd_ptr <= ~rd_ptr;
                count <= count + 2'(push) - 2'(pop);
            end
        end
    end

    // output stage holds the head word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_valid <= 1'b0;
            tx_word  <= '0;
        end else if (ce) begin
            tx_valid <= (count != 2'h0) && !req.abort && !(pop && count == 2'h1);
            tx_word  <= pop ? buf_q[~rd_ptr] : buf_q[rd_ptr];
        end
    end

    // ------------------------------------------------------------
    // bus activity and network fault
    // ------------------------------------------------------------
    // change counts once second and third stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_pin   <= 3'h0;
            bus_act <= 1'b0;
        end else if (ce) begin
            b_pin <= {b_pin[1:0], bus_active_pin};
            if (b_pin[2] == b_pin[1]) bus_act <= b_pin[2];
        end
    end

    // timer runs while driving without seeing activity
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flt_cnt <= 10'h0;
            fault   <= 1'b0;
        end else if (ce) begin
            if (bus_act || !tx_driving) begin
                flt_cnt <= 10'h0;
            end else if (flt_cnt != 10'(VLC_FAULT_CYC)) begin
                flt_cnt <= flt_cnt + 10'h1;
            end
            if (bus_act) fault <= 1'b0;
            else if (flt_cnt == 10'(VLC_FAULT_CYC - 1)) fault <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // clock divider
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt   <= 5'h0;
            link_tick <= 1'b0;
        end else if (ce) begin
            link_tick <= (div_cnt >= div_end);
            div_cnt   <= (div_cnt >= div_end) ? 5'h0 : div_cnt + 5'h1;
        end
    end

    // ------------------------------------------------------------
    // status and interrupt
    // ------------------------------------------------------------
    // receive state encode, completion code cases first
    always_comb begin
        next_rxs = RS_EMPTY;
        if (rx_head_code) begin
            if (rx_frame_behind) next_rxs = RS_CODE_FRM;
            else if (rx_count > 4'h1) next_rxs = RS_CODE_MORE;
            else next_rxs = RS_CODE_ONLY;
        end else if (rx_count == 4'h0) begin
            next_rxs = RS_EMPTY;
        end else if (rx_count == VLC_RX_POS13 && !rx_code_present) begin
            next_rxs = RS_DATA13;
        end else if (rx_count == 4'h1) begin
            next_rxs = RS_ONE;
        end else if (rx_code_present) begin
            next_rxs = RS_CODE;
        end else begin
            next_rxs = RS_MANY;
        end
    end

    // live status refreshed every cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= 8'h08;
        end else if (ce) begin
            status[VLC_ST_RX_LSB +: 3] <= next_rxs;
            status[VLC_ST_IDLE]        <= !bus_act;
            status[VLC_ST_FAULT]       <= fault;
            status[VLC_ST_HS]          <= cfg[VLC_HS_BIT];
            status[VLC_ST_TX_LSB +: 2] <= (count == 2'h0) ? TS_EMPTY
                                        : (count == 2'h1) ? TS_DATA : TS_FULL;
        end
    end

    // mask wins over every source; mode adds the extra one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= !cfg[VLC_INTERRUPT_MASK_BIT]
                   && (irq_default || (cfg[VLC_INTERRUPT_SOURCE_MODE_BIT] && irq_extra));
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_ifr_cmd;
        exec && (cmd[VLC_GENERAL_COMMAND_LSB +: 3] == GC_IFRC);
    endsequence
    sequence s_ifr_out;
        req.ifr && req.ifr_crc;
    endsequence
    AST_IFR_CRC: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ifr_cmd |=> s_ifr_out) else $error("ifr with crc not requested");
    AST_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd[VLC_GENERAL_COMMAND_LSB +: 3] == GC_ABORT |=> req.abort ##1 count == 2'h0)
        else $error("abort did not empty buffer");
    AST_PUSH: assert property (@(posedge aclk) disable iff (!aresetn)
        push && !pop && !req.abort |=> count == $past(count) + 2'h1)
        else $error("transmit load lost");
    AST_CFGI: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && bt == BT_CFGI |=> cfg == $past(wd[VLC_DATA_LSB +: 8]))
        else $error("immediate config not applied");
    AST_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && (bt == BT_DROP || bt == 3'h2) && !frame_done |=> $stable(cfg) && !push)
        else $error("dropped byte changed state");
    AST_FLUSH: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && cmd[VLC_RFC_LSB +: 2] == 2'h1 |=> !req.flush_byte && !req.flush_frame)
        else $error("reserved receive command acted");
    AST_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cfg[VLC_INTERRUPT_MASK_BIT] |=> !irq) else $error("masked interrupt raised");
    AST_EXTRA: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !cfg[VLC_INTERRUPT_MASK_BIT] && !cfg[VLC_INTERRUPT_SOURCE_MODE_BIT] && !irq_default |=> !irq)
        else $error("extra source not gated");
    AST_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && bus_act |=> !fault) else $error("fault held during activity");
    AST_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && $past(ce) |-> status[VLC_ST_IDLE] == !$past(bus_act))
        else $error("idle bit wrong");
    AST_TXFULL: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && count == 2'h2 && !req.abort |=> status[VLC_ST_TX_LSB +: 2] == TS_FULL)
        else $error("full not reported");
endmodule

// ### dv/vlc_link_model.sv
// link engine stand-in: takes transmit words and gathers request pulses
`timescale 1ns/1ps
module vlc_link_model
    import vlc_pkg::*;
(
    // clock and bench controls
    input  wire logic     aclk,
    input  wire logic     stall,
    input  wire logic     clr,
    // transmit stream and requests
    input  wire vlc_txw_s tx_word,
    input  wire logic     tx_valid,
    output logic          tx_ready,
    input  wire vlc_req_s req,
    // what was seen
    output vlc_txw_s      got,
    output vlc_txw_s      prev,
    output vlc_req_s      seen
);
    // stall holds ready low so the buffer must keep every word
    assign tx_ready = !stall;
    // keep the two latest words and every pulse since the last clear
    always_ff @(posedge aclk) begin
        if (tx_valid && tx_ready) begin
            got  <= tx_word;
            prev <= got;
        end
        seen <= clr ? '0 : (seen | req);
    end
endmodule

// ### dv/vlc_cmd_status_tb.sv
// self-checking bench for the link command and status block
`timescale 1ns/1ps
module vlc_cmd_status_tb import vlc_pkg::*;;
    logic aclk = 0, aresetn = 0, ce = 1, stall = 0, clr = 0, frame_done = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, tx_driving = 0;
    logic rx_head_code = 0, rx_code_present = 0, rx_frame_behind = 0, bus_active_pin = 0;
    logic irq_default = 0, irq_extra = 0, awready, wready, bvalid, arready, rvalid;
    logic irq, link_tick, tx_valid, tx_ready, test_mode;
    logic [3:0] awaddr = '0, araddr = '0, wstrb = 4'hf, rx_count = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [1:0] bresp, rresp, r, tx_result = '0, test_cfg;
    vlc_txw_s tx_word, got, prev;
    vlc_req_s req, seen;
    int fail_count = 0, cmp_count = 0, cyc = 0, per = 0, tc = 0;
    // command byte then expected request pulses
    logic [15:0] gt [10] = '{16'h2080, 16'h4040, 16'h6030, 16'h8008, 16'ha020,
                             16'hc000, 16'he004, 16'h0100, 16'h0202, 16'h0301};
    // count, head code, code present, frame behind, expected state
    logic [9:0] rt [8] = '{10'h000, 10'h044, 10'h141, 10'h343, 10'h0d2, 10'h07e,
                           10'h135, 10'h077};
    vlc_cmd_status u_vlc_cmd_status (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .tx_word, .tx_valid, .tx_ready, .req,
        .rx_count, .rx_head_code, .rx_code_present, .rx_frame_behind, .frame_done,
        .tx_result, .bus_active_pin, .tx_driving, .irq_default, .irq_extra, .irq,
        .link_tick, .test_mode, .test_cfg);
    vlc_link_model u_vlc_link_model (.aclk, .stall, .clr, .tx_word, .tx_valid,
        .tx_ready, .req, .got, .prev, .seen);
    initial forever #50 aclk = ~aclk;
    // tick period meter and hang guard
    always @(posedge aclk) begin
        cyc++;
        tc <= link_tick ? 1 : tc + 1;
        if (link_tick) per <= tc;
        if (cyc == 6000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask
    // handshakes are read at the falling edge, as they stand at the next rise
    task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ta, tw, tb;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
        do begin
            @(negedge aclk);
            {ta, tw, tb, rs} = {awready, wready, bvalid, bresp};
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
        // one more edge so registered effects of the write have landed
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta, tr;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(negedge aclk);
            {ta, tr, v, rs} = {arready, rvalid, rdata, rresp};
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
    endtask
    task tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(VLC_ADDR_STAT, d, r);
        chk("status", 32'h8, d);
        rd(4'hc, d, r);
        chk("rresp", AXI_SLVERR, r);
        wr(VLC_ADDR_STAT, '0, r);
        chk("bresp", AXI_SLVERR, r);
        foreach (gt[i]) begin
            clr <= 1'b1;
            @(posedge aclk);
            clr <= 1'b0;
            wr(VLC_ADDR_CMD, 32'(gt[i][15:8]), r);
            chk("req", 32'(gt[i][7:0]), 32'(seen));
        end
        $display("test commands done");
        // immediate config, then staged config waits for frame end
        wr(VLC_ADDR_CMD, 32'hc818, r);
        rd(VLC_ADDR_STAT, d, r);
        chk("hs", 1, d[VLC_ST_HS]);
        repeat (8) @(posedge aclk);
        chk("tick", 3, per);
        wr(VLC_ADDR_CMD, 32'h4810, r);
        wr(VLC_ADDR_CMD, 32'h5508, r);
        rd(VLC_ADDR_CFG, d, r);
        chk("cfg", 32'hc8, d);
        frame_done <= 1'b1;
        irq_default <= 1'b1;
        @(posedge aclk);
        frame_done <= 1'b0;
        repeat (30) @(posedge aclk);
        chk("tick", 12, per);
        chk("irq", 0, irq);
        wr(VLC_ADDR_CFG, 32'h0, r);
        chk("irq", 1, irq);
        irq_default <= 1'b0;
        irq_extra <= 1'b1;
        wr(VLC_ADDR_CFG, 32'h7, r);
        chk("irq", 0, irq);
        chk("test", 3'b111, {test_mode, test_cfg});
        wr(VLC_ADDR_CFG, 32'h13, r);
        chk("irq", 1, irq);
        chk("test", 3'b000, {test_mode, test_cfg});
        $display("test config done");
        // stalled receiver: two words fill the buffer, none is lost
        stall <= 1'b1;
        wr(VLC_ADDR_CMD, 32'h1114, r);
        wr(VLC_ADDR_CMD, 32'h2204, r);
        rd(VLC_ADDR_STAT, d, r);
        chk("txst", TS_FULL, d[7:6]);
        stall <= 1'b0;
        wr(VLC_ADDR_CMD, 32'h330c, r);
        chk("prev", 10'h046, prev);
        wr(VLC_ADDR_CMD, 32'h441c, r);
        repeat (4) @(posedge aclk);
        chk("got", 10'h113, got);
        chk("prev", 10'h0cd, prev);
        rd(VLC_ADDR_STAT, d, r);
        chk("txst", TS_EMPTY, d[7:6]);
        $display("test transmit done");
        foreach (rt[i]) begin
            {rx_count, rx_head_code, rx_code_present, rx_frame_behind} <= rt[i][9:3];
            rd(VLC_ADDR_STAT, d, r);
            chk("rx", rt[i][2:0], d[2:0]);
        end
        // fault persists across reads, cleared by bus activity
        tx_driving <= 1'b1;
        repeat (VLC_FAULT_CYC + 10) @(posedge aclk);
        repeat (2) rd(VLC_ADDR_STAT, d, r);
        chk("fault", 2'b11, d[4:3]);
        bus_active_pin <= 1'b1;
        tx_result <= 2'h3;
        repeat (6) @(posedge aclk);
        rd(VLC_ADDR_STAT, d, r);
        chk("fault", 2'b00, d[4:3]);
        chk("txres", 2'h3, d[9:8]);
        $display("test status done");
        tally_and_finish();
    end
endmodule
